/* File: battery_afe_register_map.sv */
/*
  Register bank of the battery front end: status, analog selector, sleep,
  feature configuration and write unlock, reached by a byte port.
  Assumes the serial-bus engine drives the access port on mclk, and that
  wake and over-temperature comparators are asynchronous to mclk.
*/
`timescale 1ns/1ps
`include "battery_afe_map.svh"

module battery_afe_register_map #(
  parameter int SYNC_STAGES = 2
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Register access port from the serial-bus engine.
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // Analog conditions.
  input wire logic wake_pin,
  input wire logic ext_overtemp,
  input wire logic int_overtemp,
  // Control outputs.
  output logic sleep_mode,
  output logic regulator_off,
  output battery_afe_pkg::feature_ctrl_type feature_ctrl,
  output battery_afe_pkg::mux_select_type mux_select
);

  if (SYNC_STAGES < 2) begin : g_sync_check
    $error("SYNC_STAGES must be at least 2.");
  end

  logic [SYNC_STAGES-1:0] wake_sync_reg;
  logic [SYNC_STAGES-1:0] ext_sync_reg;
  logic [SYNC_STAGES-1:0] int_sync_reg;
  logic wake_prev_reg;
  logic wake_s;
  logic ext_s;
  logic int_s;

  logic [7:0] analog_reg, analog_next;
  logic [7:0] control_reg, control_next;
  logic [7:0] feature_reg, feature_next;
  logic [7:0] unlock_reg, unlock_next;
  logic ext_flag_reg, ext_flag_next;
  logic int_flag_reg, int_flag_next;
  logic [7:0] rdata_next;
  logic regulator_off_next;
  battery_afe_pkg::mux_select_type mux_next;

  logic wr_analog, wr_control, wr_feature, wr_unlock;
  logic rd_opstat, force_reset, wake_edge;
  logic [3:0] ao_next;

  assign wake_s = wake_sync_reg[SYNC_STAGES-1];
  assign ext_s = ext_sync_reg[SYNC_STAGES-1];
  assign int_s = int_sync_reg[SYNC_STAGES-1];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wake_sync_reg <= '0;
      ext_sync_reg <= '0;
      int_sync_reg <= '0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[SYNC_STAGES-2:0], wake_pin};
      ext_sync_reg <= {ext_sync_reg[SYNC_STAGES-2:0], ext_overtemp};
      int_sync_reg <= {int_sync_reg[SYNC_STAGES-2:0], int_overtemp};
    end
  end

  always_comb begin
    wr_analog = reg_write && reg_addr == `ADDR_ANALOG_OUTPUT_SELECT;
    wr_control = reg_write && reg_addr == `ADDR_SLEEP_CONTROL;
    wr_unlock = reg_write && reg_addr == `ADDR_WRITE_UNLOCK;
    wr_feature = reg_write && reg_addr == `ADDR_FEATURE_CONFIG
                 && unlock_reg[`UNLOCK_BIT];
    force_reset = wr_feature && reg_wdata[`FORCE_RESET_BIT];
    rd_opstat = reg_read && reg_addr == `ADDR_OPERATING_STATUS;
    wake_edge = !feature_reg[`WAKE_DISABLE_BIT]
                && (feature_reg[`WAKE_POLARITY_BIT]
                    ? (wake_s && !wake_prev_reg)
                    : (!wake_s && wake_prev_reg));

    analog_next = analog_reg;
    control_next = control_reg;
    feature_next = feature_reg;
    unlock_next = unlock_reg;
    if (wr_analog) begin
      analog_next = reg_wdata & `ANALOG_WRITE_MASK;
    end
    if (wake_edge) begin
      control_next[`SLEEP_BIT] = 1'b0;
    end
    if (wr_control) begin
      control_next = reg_wdata & `CONTROL_WRITE_MASK;
    end
    if (wr_feature) begin
      feature_next = reg_wdata & `FEATURE_WRITE_MASK;
    end
    if (wr_unlock) begin
      unlock_next = reg_wdata & `UNLOCK_WRITE_MASK;
    end

    ext_flag_next = ext_s || (ext_flag_reg && !rd_opstat);
    int_flag_next = int_s || (int_flag_reg && !rd_opstat);

    if (force_reset) begin
      analog_next = `ZERO_BYTE;
      control_next = `ZERO_BYTE;
      feature_next = `ZERO_BYTE;
      unlock_next = `ZERO_BYTE;
      ext_flag_next = 1'b0;
      int_flag_next = 1'b0;
    end

    rdata_next = `ZERO_BYTE;
    case (reg_addr)
      `ADDR_CONFIG_STATUS: begin
        rdata_next[`SINGLE_DEVICE_BIT] = `SINGLE_DEVICE_VALUE;
        rdata_next[`WAKE_STATUS_BIT] = feature_reg[`WAKE_POLARITY_BIT]
                                       ? wake_s : !wake_s;
      end
      `ADDR_OPERATING_STATUS: begin
        rdata_next[`EXT_OVERTEMP_BIT] = ext_flag_reg;
        rdata_next[`INT_OVERTEMP_BIT] = int_flag_reg;
      end
      `ADDR_ANALOG_OUTPUT_SELECT: rdata_next = analog_reg;
      `ADDR_SLEEP_CONTROL: rdata_next = control_reg;
      `ADDR_FEATURE_CONFIG: rdata_next = feature_reg;
      `ADDR_WRITE_UNLOCK: rdata_next = unlock_reg;
      default: rdata_next = `ZERO_BYTE;
    endcase

    regulator_off_next = control_next[`SLEEP_BIT]
                         || feature_next[`REGULATOR_DISABLE_BIT];
    ao_next = analog_next[`AO_FIELD_MSB:0];
    mux_next.output_off = ao_next == `AO_NONE;
    mux_next.cell_index = (ao_next <= `AO_CELL_LAST) ? ao_next[2:0] : 3'h0;
    mux_next.ext_temp = ao_next == `AO_EXT_TEMP;
    mux_next.int_temp = ao_next == `AO_INT_TEMP;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      analog_reg <= `ZERO_BYTE;
      control_reg <= `ZERO_BYTE;
      feature_reg <= `ZERO_BYTE;
      unlock_reg <= `ZERO_BYTE;
      ext_flag_reg <= 1'b0;
      int_flag_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
      reg_rdata <= `ZERO_BYTE;
      reg_rdata_valid <= 1'b0;
      regulator_off <= 1'b0;
      mux_select <= `MUX_SELECT_RESET;
    end else begin
      analog_reg <= analog_next;
      control_reg <= control_next;
      feature_reg <= feature_next;
      unlock_reg <= unlock_next;
      ext_flag_reg <= ext_flag_next;
      int_flag_reg <= int_flag_next;
      wake_prev_reg <= wake_s;
      if (reg_read) begin
        reg_rdata <= rdata_next;
      end
      reg_rdata_valid <= reg_read;
      regulator_off <= regulator_off_next;
      mux_select <= mux_next;
    end
  end

  assign sleep_mode = control_reg[`SLEEP_BIT];
  assign feature_ctrl.auto_temp_scan_disable = feature_reg[`SCAN_DISABLE_BIT];
  assign feature_ctrl.regulator_disable = feature_reg[`REGULATOR_DISABLE_BIT];
  assign feature_ctrl.sensor_supply_on = feature_reg[`SENSOR_SUPPLY_BIT];
  assign feature_ctrl.wake_pin_disable = feature_reg[`WAKE_DISABLE_BIT];
  assign feature_ctrl.wake_edge_polarity = feature_reg[`WAKE_POLARITY_BIT];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence read_config_s;
    reg_read && reg_addr == `ADDR_CONFIG_STATUS;
  endsequence

  sequence unlocked_reset_write_s;
    reg_write && reg_addr == `ADDR_FEATURE_CONFIG
    && unlock_reg[`UNLOCK_BIT] && reg_wdata[`FORCE_RESET_BIT];
  endsequence

  a_single_device_bit: assert property (
    read_config_s |=> reg_rdata_valid && reg_rdata[`SINGLE_DEVICE_BIT])
    else $error("Single-device bit did not read one.");

  a_wake_status_value: assert property (
    read_config_s |=> reg_rdata[`WAKE_STATUS_BIT]
      == ($past(feature_reg[`WAKE_POLARITY_BIT]) ? $past(wake_s)
          : !$past(wake_s)))
    else $error("Wake status does not follow pin and polarity.");

  a_ext_flag_set: assert property (
    ext_s && !force_reset |=> ext_flag_reg)
    else $error("External over-temp flag not held while condition true.");

  a_int_flag_clear: assert property (
    int_flag_reg && !int_s && rd_opstat |=> !int_flag_reg)
    else $error("Internal over-temp flag did not clear on read.");

  a_flag_no_stray_clear: assert property (
    ext_flag_reg && !rd_opstat && !force_reset |=> ext_flag_reg)
    else $error("External over-temp flag cleared without a read.");

  a_feature_locked: assert property (
    reg_write && reg_addr == `ADDR_FEATURE_CONFIG && !unlock_reg[`UNLOCK_BIT]
    |=> $stable(feature_reg))
    else $error("Feature register changed while locked.");

  a_force_reset_zero: assert property (
    unlocked_reset_write_s |=> analog_reg == `ZERO_BYTE
      && control_reg == `ZERO_BYTE && feature_reg == `ZERO_BYTE
      && unlock_reg == `ZERO_BYTE && !sleep_mode)
    else $error("Force reset left a register nonzero.");

  a_sleep_write_clear: assert property (
    reg_write && reg_addr == `ADDR_SLEEP_CONTROL && !reg_wdata[`SLEEP_BIT]
    |=> !sleep_mode)
    else $error("Sleep bit not cleared by write of zero.");

  a_sleep_wake_clear: assert property (
    sleep_mode && feature_reg[`WAKE_POLARITY_BIT]
    && !feature_reg[`WAKE_DISABLE_BIT] && wake_s && !wake_prev_reg
    && !wr_control |=> !sleep_mode)
    else $error("Rising wake edge did not clear sleep.");

  a_sleep_regulator_off: assert property (
    sleep_mode |-> regulator_off)
    else $error("Regulator not off during sleep.");

  a_analog_decode: assert property (
    mux_select.ext_temp == (analog_reg[`AO_FIELD_MSB:0] == `AO_EXT_TEMP)
    && mux_select.output_off == (analog_reg[`AO_FIELD_MSB:0] == `AO_NONE))
    else $error("Analog selector decode mismatch.");

endmodule : battery_afe_register_map

/* File: battery_afe_map.svh */
/*
  Address map, bit positions, reset values and selector codes for the
  battery front-end register bank.
  Assumes it is included by bare name from the design.
*/
//
// Functional notes
// - Config status read-only, bit 5 constant one.
// - Wake status bit follows pin through polarity.
// - External over-temp flag; read clears once gone.
// - Internal over-temp flag; read clears once gone.
// - Other status bits follow their condition only.
// - Feature register writable only while unlock set.
// - Feature bits: scan, regulator, supply, reset, wake.
// - Writing one acts; status one means true.
// - Sleep bit zero at reset, cleared by writing zero.
// - Sleep cleared by wake edge of chosen polarity.
// - Force-reset bit returns writable registers and flags to zero.
// - Sleep turns regulator off, keeps analog select.
// - Analog select decodes none, cells, temperatures.
`ifndef BATTERY_AFE_MAP_SVH
`define BATTERY_AFE_MAP_SVH

`define ADDR_CONFIG_STATUS 8'h00
`define ADDR_OPERATING_STATUS 8'h01
`define ADDR_ANALOG_OUTPUT_SELECT 8'h03
`define ADDR_SLEEP_CONTROL 8'h04
`define ADDR_FEATURE_CONFIG 8'h07
`define ADDR_WRITE_UNLOCK 8'h08

`define ZERO_BYTE 8'h00
`define SINGLE_DEVICE_VALUE 1'b1

`define SINGLE_DEVICE_BIT 5
`define WAKE_STATUS_BIT 4
`define EXT_OVERTEMP_BIT 5
`define INT_OVERTEMP_BIT 4
`define SLEEP_BIT 7
`define SCAN_DISABLE_BIT 7
`define REGULATOR_DISABLE_BIT 6
`define SENSOR_SUPPLY_BIT 5
`define FORCE_RESET_BIT 2
`define WAKE_DISABLE_BIT 1
`define WAKE_POLARITY_BIT 0
`define UNLOCK_BIT 7

`define ANALOG_WRITE_MASK 8'hCF
`define CONTROL_WRITE_MASK 8'h80
`define FEATURE_WRITE_MASK 8'hE7
`define UNLOCK_WRITE_MASK 8'h98

`define AO_FIELD_MSB 3
`define AO_NONE 4'h0
`define AO_CELL_LAST 4'h7
`define AO_EXT_TEMP 4'h8
`define AO_INT_TEMP 4'h9
`define MUX_SELECT_RESET 6'h20

`endif

/* File: battery_afe_pkg.sv */
/*
  Types shared by the battery front-end register bank.
  Assumes the address map header sits in the same folder.
*/
package battery_afe_pkg;

  typedef struct packed {
    logic auto_temp_scan_disable;
    logic regulator_disable;
    logic sensor_supply_on;
    logic wake_pin_disable;
    logic wake_edge_polarity;
  } feature_ctrl_type;

  typedef struct packed {
    logic output_off;
    logic [2:0] cell_index;
    logic ext_temp;
    logic int_temp;
  } mux_select_type;

endpackage : battery_afe_pkg

/* File: afe_host_model.sv */
/*
  Host model: single-byte register writes and reads on the access port.
  Assumes the bench calls its tasks and that mclk runs freely.
*/
`timescale 1ns/1ps

module afe_host_model (
  // Clock.
  input wire logic mclk,
  // Register access port.
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid
);
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Bits the host may set; reserved positions of 03, 04 and 08 and all of 02 are sent as zero, other addresses below 09 as given, 09 and above not sent.
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      8'h02: keep_mask = 8'h00;
      8'h03: keep_mask = 8'hCF;
      8'h04: keep_mask = 8'h80;
      8'h08: keep_mask = 8'h98;
      default: keep_mask = 8'hFF;
    endcase
  endfunction : keep_mask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a < 8'h09) begin
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d & keep_mask(a);
      @(posedge mclk);
      reg_write <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~reg_wdata;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rdata_valid;
  endtask : rd
endmodule : afe_host_model

/* File: battery_afe_register_map_tb.sv */
/*
  Self-checking bench for the battery front-end register bank.
  Assumes the design and the host model sit in the same folder.
*/
`timescale 1ns/1ps

module battery_afe_register_map_tb;
  logic mclk, reset_n, reg_write, reg_read, reg_rdata_valid, vld;
  logic wake_pin, ext_overtemp, int_overtemp, sleep_mode, regulator_off;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
  logic [5:0] mexp;
  battery_afe_pkg::feature_ctrl_type feature_ctrl;
  battery_afe_pkg::mux_select_type mux_select;
  int bad_count = 0;
  int num_checks = 0;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  row_type rows [11] = '{'{8'h03, 8'hFF, 8'hCF}, '{8'h04, 8'h80, 8'h80},
    '{8'h04, 8'h00, 8'h00}, '{8'h07, 8'hE3, 8'h00}, '{8'h08, 8'hFF, 8'h98},
    '{8'h07, 8'hFB, 8'hE3}, '{8'h00, 8'hFF, 8'h20}, '{8'h08, 8'h00, 8'h00},
    '{8'h07, 8'h00, 8'hE3}, '{8'h01, 8'hFF, 8'h00}, '{8'h02, 8'hFF, 8'h00}};

  battery_afe_register_map #(.SYNC_STAGES(2)) battery_afe_register_map_inst (
    .mclk(mclk), .reset_n(reset_n), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .wake_pin(wake_pin), .ext_overtemp(ext_overtemp),
    .int_overtemp(int_overtemp), .sleep_mode(sleep_mode),
    .regulator_off(regulator_off), .feature_ctrl(feature_ctrl),
    .mux_select(mux_select));

  afe_host_model afe_host_model_inst (
    .mclk(mclk), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid));

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    afe_host_model_inst.wr(a, d);
    #1;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    afe_host_model_inst.rd(a, got, vld);
    chk("read valid", 8'h01, {7'h00, vld});
    chk("read data", e, got);
  endtask : rdc

  task automatic wait_sync;
    repeat (4) @(posedge mclk);
    #1;
  endtask : wait_sync

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #1000000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    wake_pin = 1'b0;
    ext_overtemp = 1'b0;
    int_overtemp = 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    wait_sync();
    chk("outputs", 8'h00, {1'b0, sleep_mode, regulator_off, feature_ctrl});
    chk("mux", 8'h20, {2'b00, mux_select});
    for (int a = 1; a < 10; a++) rdc(a[7:0], 8'h00);
    rdc(8'h00, 8'h30);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    chk("features", 8'h3F, {2'b00, regulator_off, feature_ctrl});
    wr(8'h08, 8'h80);
    wr(8'h07, 8'h01);
    @(posedge mclk) wake_pin <= 1'b1;
    wait_sync();
    repeat (2) rdc(8'h00, 8'h30);
    chk("wake status", 8'h10, got & 8'h10);
    wr(8'h03, 8'h05);
    wr(8'h04, 8'h80);
    chk("sleep", 8'h03, {6'h00, sleep_mode, regulator_off});
    @(posedge mclk) wake_pin <= 1'b0;
    wait_sync();
    chk("sleep", 8'h01, {7'h00, sleep_mode});
    @(posedge mclk) wake_pin <= 1'b1;
    wait_sync();
    chk("sleep", 8'h00, {7'h00, sleep_mode});
    rdc(8'h03, 8'h05);
    wr(8'h07, 8'h00);
    wr(8'h04, 8'h80);
    @(posedge mclk) wake_pin <= 1'b0;
    wait_sync();
    chk("sleep", 8'h00, {7'h00, sleep_mode});
    for (int c = 0; c < 10; c++) begin
      wr(8'h03, c[7:0]);
      if (c == 0) mexp = 6'b100000;
      else if (c < 8) mexp = {1'b0, c[2:0], 2'b00};
      else mexp = (c == 8) ? 6'b000010 : 6'b000001;
      chk("mux", {2'b00, mexp}, {2'b00, mux_select});
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      ext_overtemp <= (k == 0);
      int_overtemp <= (k == 1);
      wait_sync();
      repeat (2) rdc(8'h01, k ? 8'h10 : 8'h20);
      @(posedge mclk);
      ext_overtemp <= 1'b0;
      int_overtemp <= 1'b0;
      wait_sync();
      rdc(8'h01, k ? 8'h10 : 8'h20);
      rdc(8'h01, 8'h00);
    end
    wr(8'h03, 8'hC5);
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h80);
    wr(8'h07, 8'h21);
    wr(8'h07, 8'h04);
    chk("outputs", 8'h00, {1'b0, sleep_mode, regulator_off, feature_ctrl});
    chk("mux", 8'h20, {2'b00, mux_select});
    for (int a = 3; a < 9; a++) rdc(a[7:0], 8'h00);
    rdc(8'h00, 8'h30);
    wr(8'h03, 8'h05);
    @(posedge mclk) reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("mux", 8'h20, {2'b00, mux_select});
    rdc(8'h03, 8'h00);
    report_and_stop();
  end
endmodule : battery_afe_register_map_tb
